// ---- include/ulc_params.svh ----
/*
 * constants of the serial port control block: offsets, reset values
 * and timing counts. assumes inclusion by bare name from design files.
 */
`ifndef ULC_PARAMS_SVH
`define ULC_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ULC_ADDR_W      28
`define ULC_OFS_CTL     28'hFFFFA00
`define ULC_OFS_OPT     28'hFFFFA03
`define ULC_OFS_STAT    28'hFFFFA04
`define ULC_OFS_TXB     28'hFFFFA05
`define ULC_OFS_RXB     28'hFFFFA06

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ULC_CTL_RST     8'h10
`define ULC_OPT_RST     8'h14
`define ULC_BUF_RST     8'hFF

// ----------------------------------------------------------------
// field positions of the option register
// ----------------------------------------------------------------
`define ULC_OPT_BRX_TRIG 6
`define ULC_OPT_BTX_TRIG 5

// ----------------------------------------------------------------
// timing: 16 ticks per bit, sample in mid bit
// ----------------------------------------------------------------
`define ULC_OS_LAST     4'hF
`define ULC_OS_MID      4'h7
`define ULC_BRK_BASE    5'h0D
`define ULC_BRK_MIN     8'hB0
`define ULC_BRK_SAT     8'hFF
`define ULC_OS_DIV      16

`endif

// ---- include/ulc_pkg.sv ----
/*
 * types of the serial port control block.
 * assumes nothing beyond a sv compiler.
 */
`default_nettype none

package ulc_pkg;

	// ------------------------------------------------------------
	// register layouts
	// ------------------------------------------------------------
	typedef struct packed {
		logic       unit_power;
		logic       transmit_enable;
		logic       receive_enable;
		logic       bit_order_select;
		logic [1:0] parity_select;
		logic       char_length_select;
		logic       stop_length_select;
	} ulc_ctl_s;

	typedef struct packed {
		logic [2:0] break_length;
		logic       tx_invert;
		logic       rx_invert;
	} ulc_opt_s;

	// ------------------------------------------------------------
	// state machines
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		TX_IDLE  = 6'h01,
		TX_START = 6'h02,
		TX_DATA  = 6'h04,
		TX_PAR   = 6'h08,
		TX_STOP  = 6'h10,
		TX_BRK   = 6'h20
	} ulc_tx_e;

	typedef enum logic [4:0] {
		RX_IDLE  = 5'h01,
		RX_START = 5'h02,
		RX_DATA  = 5'h04,
		RX_PAR   = 5'h08,
		RX_STOP  = 5'h10
	} ulc_rx_e;

endpackage

`default_nettype wire

// ---- src/ulc_tick_div.sv ----
/*
 * oversample tick divider: one-cycle enable every DIV clocks.
 * assumes a single clock; run low holds the count at zero.
 */
`default_nettype none

module ulc_tick_div #(
	parameter int DIV = 16
) (
	input  wire logic core_clk,
	input  wire logic srst,
	input  wire logic run,
	output logic      tick
);
	logic [15:0] cnt;
	wire         wrap = (cnt == 16'(DIV - 1));

	always_ff @(posedge core_clk) begin
		if (srst || !run) begin
			cnt  <= 16'h0000;
			tick <= 1'b0;
		end else begin
			cnt  <= wrap ? 16'h0000 : cnt + 16'h0001;
			tick <= wrap;
		end
	end
endmodule

`default_nettype wire

// ---- src/ulc_rx_sync.sv ----
/*
 * two-stage synchroniser for the serial input pin plus level inversion.
 * assumes the pin is asynchronous to core_clk.
 */
`default_nettype none

module ulc_rx_sync (
	input  wire logic core_clk,
	input  wire logic srst,
	input  wire logic pin,
	input  wire logic invert,
	output logic      level
);
	logic meta;
	logic stable;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			meta   <= 1'b1;
			stable <= 1'b1;
		end else begin
			meta   <= pin;
			stable <= meta;
		end
	end

	assign level = stable ^ invert;
endmodule

`default_nettype wire

// ---- src/ulc_top.sv ----
/*
 * serial port with lin break support: control and option registers,
 * transmitter with buffer, receiver, break transmit and break receive.
 * assumes a register master on core_clk with one-cycle strobes and
 * read data taken the cycle after the read strobe.
 */
`include "ulc_params.svh"
`default_nettype none

// Summary of operation
// - writing transmit buffer starts a transmission
// - irq pulse when buffer moves to shifter
// - main control resets 10H, fixed bit layout
// - power low holds unit in reset
// - unpowered output idles high, low if inverted
// - parity select: none, zero, odd, even
// - zero parity never flags parity error
// - length bit selects seven or eight bits
// - stop bit selects one or two stops
// - option register resets 14H, fixed layout
// - break flag high during break reception
// - break reception error restarts, flag stays
// - break receive trigger arms, reads zero
// - break transmit trigger starts break, reads zero
// - break length code gives 13 to 20
// - tx invert flips the output pin
// - rx invert flips the sampled input
module ulc_top #(
	parameter int OS_DIV = `ULC_OS_DIV
) (
	input  wire logic                   core_clk,
	input  wire logic                   srst,
	input  wire logic [`ULC_ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [7:0]             reg_rdata,
	input  wire logic                   serial_in_pin,
	output logic                        serial_out_pin,
	output logic                        transmit_enable_irq
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic data_parity(input logic [7:0] d,
		input logic len8, input logic lsb_first);
		logic [7:0] mask;
		mask = len8 ? 8'hFF : (lsb_first ? 8'h7F : 8'hFE);
		return ^(d & mask);
	endfunction

	function automatic logic parity_bit(input logic p,
		input logic [1:0] sel);
		return sel[1] ? (sel[0] ? p : ~p) : 1'b0;
	endfunction

	// ------------------------------------------------------------
	// registers and decode
	// ------------------------------------------------------------
	ulc_pkg::ulc_ctl_s ctl;
	ulc_pkg::ulc_opt_s opt;
	logic [7:0]        tx_buf;
	logic [7:0]        rx_buf;
	logic              brk_flag;
	logic              par_err;
	logic              frm_err;
	logic              tx_full;

	wire sel_ctl  = (reg_addr == `ULC_OFS_CTL);
	wire sel_opt  = (reg_addr == `ULC_OFS_OPT);
	wire sel_stat = (reg_addr == `ULC_OFS_STAT);
	wire sel_txb  = (reg_addr == `ULC_OFS_TXB);
	wire sel_rxb  = (reg_addr == `ULC_OFS_RXB);

	wire wr_ctl  = reg_wr && sel_ctl;
	wire wr_opt  = reg_wr && sel_opt;
	wire wr_stat = reg_wr && sel_stat;
	wire wr_txb  = reg_wr && sel_txb;

	wire powered = ctl.unit_power;
	wire tx_run  = powered && ctl.transmit_enable;
	wire rx_run  = powered && ctl.receive_enable;

	wire brk_tx_req = wr_opt && reg_wdata[`ULC_OPT_BTX_TRIG]
		&& tx_run && !brk_flag;
	wire brk_rx_req = wr_opt && reg_wdata[`ULC_OPT_BRX_TRIG]
		&& rx_run && !brk_flag;

	ulc_pkg::ulc_tx_e tx_state;
	wire tsf = (tx_state != ulc_pkg::TX_IDLE) || tx_full;

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	wire [7:0] opt_view = {brk_flag, 2'b00, opt};
	wire [7:0] stat_view = {tsf, 5'h00, par_err, frm_err};
	wire [7:0] rd_mux;
	assign rd_mux = sel_ctl  ? ctl      :
	                sel_opt  ? opt_view :
	                sel_stat ? stat_view :
	                sel_txb  ? tx_buf   :
	                sel_rxb  ? rx_buf   : 8'h00;

	always_ff @(posedge core_clk) begin
		if (srst)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
	end

	// ------------------------------------------------------------
	// control and option registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctl <= `ULC_CTL_RST;
			opt <= 5'(`ULC_OPT_RST);
		end else begin
			if (wr_ctl)
				ctl <= reg_wdata;
			if (wr_opt)
				opt <= reg_wdata[4:0];
		end
	end

	// ------------------------------------------------------------
	// oversample tick and input sampling
	// ------------------------------------------------------------
	logic os_tick;
	logic rx_in;

	ulc_tick_div #(
		.DIV(OS_DIV)
	) u_div (
		.core_clk(core_clk),
		.srst    (srst),
		.run     (powered),
		.tick    (os_tick)
	);

	ulc_rx_sync u_sync (
		.core_clk(core_clk),
		.srst    (srst),
		.pin     (serial_in_pin),
		.invert  (opt.rx_invert),
		.level   (rx_in)
	);

	// ------------------------------------------------------------
	// transmit buffer
	// ------------------------------------------------------------
	logic tx_load;
	logic brk_pend;

	always_ff @(posedge core_clk) begin
		if (srst)
			tx_buf <= `ULC_BUF_RST;
		else if (wr_txb)
			tx_buf <= reg_wdata;
	end

	always_ff @(posedge core_clk) begin
		if (srst || !tx_run)
			tx_full <= 1'b0;
		else if (wr_txb)
			tx_full <= 1'b1;
		else if (tx_load)
			tx_full <= 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (srst || !tx_run)
			brk_pend <= 1'b0;
		else if (brk_tx_req)
			brk_pend <= 1'b1;
		else if (tx_state == ulc_pkg::TX_BRK)
			brk_pend <= 1'b0;
	end

	// ------------------------------------------------------------
	// transmitter
	// ------------------------------------------------------------
	logic [7:0] tx_sh;
	logic [3:0] tx_os;
	logic [4:0] tx_cnt;
	logic       tx_par;
	logic       tx_line;

	wire lsb_first = ctl.bit_order_select;
	wire [4:0] n_bits = ctl.char_length_select ? 5'h08 : 5'h07;
	wire [4:0] brk_len = (({2'b00, opt.break_length} + 5'h03)
		& 5'h07) + `ULC_BRK_BASE;
	wire tx_bit_end = os_tick && (tx_os == `ULC_OS_LAST);
	wire [7:0] tx_next_sh = lsb_first ? {1'b0, tx_sh[7:1]}
	                                  : {tx_sh[6:0], 1'b0};
	wire tx_first = lsb_first ? tx_sh[0] : tx_sh[7];
	wire tx_next  = lsb_first ? tx_next_sh[0] : tx_next_sh[7];
	wire tx_par_on = (ctl.parity_select != 2'b00);
	wire tx_two_stop = ctl.stop_length_select && (tx_cnt == 5'h00);

	assign tx_load = (tx_state == ulc_pkg::TX_IDLE) && tx_full
		&& !brk_pend;

	always_ff @(posedge core_clk) begin
		if (srst || !tx_run)
			tx_os <= 4'h0;
		else if (tx_state == ulc_pkg::TX_IDLE)
			tx_os <= 4'h0;
		else if (os_tick)
			tx_os <= tx_os + 4'h1;
	end

	always_ff @(posedge core_clk) begin
		if (srst || !tx_run) begin
			tx_state <= ulc_pkg::TX_IDLE;
			tx_line  <= 1'b1;
			tx_cnt   <= 5'h00;
			tx_sh    <= 8'h00;
			tx_par   <= 1'b0;
		end else begin
			case (tx_state)
			ulc_pkg::TX_IDLE: begin
				tx_cnt <= 5'h00;
				if (brk_pend) begin
					tx_state <= ulc_pkg::TX_BRK;
					tx_line  <= 1'b0;
				end else if (tx_full) begin
					tx_state <= ulc_pkg::TX_START;
					tx_line  <= 1'b0;
					tx_sh    <= tx_buf;
					tx_par   <= parity_bit(data_parity(tx_buf,
						ctl.char_length_select, lsb_first),
						ctl.parity_select);
				end
			end
			ulc_pkg::TX_START: begin
				if (tx_bit_end) begin
					tx_state <= ulc_pkg::TX_DATA;
					tx_line  <= tx_first;
				end
			end
			ulc_pkg::TX_DATA: begin
				if (tx_bit_end) begin
					tx_sh  <= tx_next_sh;
					tx_cnt <= tx_cnt + 5'h01;
					if (tx_cnt == n_bits - 5'h01) begin
						tx_cnt <= 5'h00;
						if (tx_par_on) begin
							tx_state <= ulc_pkg::TX_PAR;
							tx_line  <= tx_par;
						end else begin
							tx_state <= ulc_pkg::TX_STOP;
							tx_line  <= 1'b1;
						end
					end else begin
						tx_line <= tx_next;
					end
				end
			end
			ulc_pkg::TX_PAR: begin
				if (tx_bit_end) begin
					tx_state <= ulc_pkg::TX_STOP;
					tx_line  <= 1'b1;
				end
			end
			ulc_pkg::TX_STOP: begin
				if (tx_bit_end) begin
					if (tx_two_stop)
						tx_cnt <= 5'h01;
					else
						tx_state <= ulc_pkg::TX_IDLE;
				end
			end
			ulc_pkg::TX_BRK: begin
				if (tx_bit_end) begin
					tx_cnt <= tx_cnt + 5'h01;
					if (tx_cnt == brk_len - 5'h01) begin
						tx_state <= ulc_pkg::TX_STOP;
						tx_line  <= 1'b1;
						tx_cnt   <= 5'h01;
					end
				end
			end
			default: tx_state <= ulc_pkg::TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			transmit_enable_irq <= 1'b0;
			serial_out_pin      <= 1'b1;
		end else begin
			transmit_enable_irq <= tx_run && tx_load;
			serial_out_pin <= (powered ? tx_line : 1'b1)
				^ opt.tx_invert;
		end
	end

	// ------------------------------------------------------------
	// break reception
	// ------------------------------------------------------------
	logic [7:0] brk_low;
	logic       rx_prev;

	wire rx_rise = rx_in && !rx_prev;
	wire brk_ok  = (brk_low >= `ULC_BRK_MIN);

	always_ff @(posedge core_clk) begin
		if (srst || !rx_run)
			rx_prev <= 1'b1;
		else
			rx_prev <= rx_in;
	end

	always_ff @(posedge core_clk) begin
		if (srst || !powered)
			brk_flag <= 1'b0;
		else if (brk_rx_req)
			brk_flag <= 1'b1;
		else if (brk_flag && rx_rise && brk_ok)
			brk_flag <= 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (srst || !brk_flag || rx_rise)
			brk_low <= 8'h00;
		else if (os_tick && !rx_in && brk_low != `ULC_BRK_SAT)
			brk_low <= brk_low + 8'h01;
	end

	// ------------------------------------------------------------
	// receiver
	// ------------------------------------------------------------
	ulc_pkg::ulc_rx_e rx_state;
	logic [7:0] rx_sh;
	logic [3:0] rx_os;
	logic [4:0] rx_cnt;
	logic       rx_pbit;

	wire rx_sample = os_tick && (rx_os == `ULC_OS_MID);
	wire [7:0] rx_word = ctl.char_length_select ? rx_sh :
		(lsb_first ? {1'b0, rx_sh[7:1]} : {rx_sh[6:0], 1'b0});
	wire rx_exp = parity_bit(data_parity(rx_word,
		ctl.char_length_select, lsb_first), ctl.parity_select);
	wire rx_done = (rx_state == ulc_pkg::RX_STOP) && rx_sample;
	wire set_pe = rx_done && ctl.parity_select[1]
		&& (rx_pbit != rx_exp);
	wire set_fe = rx_done && !rx_in;

	always_ff @(posedge core_clk) begin
		if (srst || !rx_run)
			rx_os <= 4'h0;
		else if (rx_state == ulc_pkg::RX_IDLE)
			rx_os <= 4'h0;
		else if (os_tick)
			rx_os <= rx_os + 4'h1;
	end

	always_ff @(posedge core_clk) begin
		if (srst || !rx_run) begin
			rx_state <= ulc_pkg::RX_IDLE;
			rx_sh    <= 8'h00;
			rx_cnt   <= 5'h00;
			rx_pbit  <= 1'b0;
		end else begin
			case (rx_state)
			ulc_pkg::RX_IDLE: begin
				rx_cnt <= 5'h00;
				if (!brk_flag && !rx_in)
					rx_state <= ulc_pkg::RX_START;
			end
			ulc_pkg::RX_START: begin
				if (rx_sample)
					rx_state <= rx_in ? ulc_pkg::RX_IDLE
					                  : ulc_pkg::RX_DATA;
			end
			ulc_pkg::RX_DATA: begin
				if (rx_sample) begin
					rx_sh  <= lsb_first ? {rx_in, rx_sh[7:1]}
					                    : {rx_sh[6:0], rx_in};
					rx_cnt <= rx_cnt + 5'h01;
					if (rx_cnt == n_bits - 5'h01)
						rx_state <= (ctl.parity_select != 2'b00)
							? ulc_pkg::RX_PAR : ulc_pkg::RX_STOP;
				end
			end
			ulc_pkg::RX_PAR: begin
				if (rx_sample) begin
					rx_pbit  <= rx_in;
					rx_state <= ulc_pkg::RX_STOP;
				end
			end
			ulc_pkg::RX_STOP: begin
				if (rx_sample)
					rx_state <= ulc_pkg::RX_IDLE;
			end
			default: rx_state <= ulc_pkg::RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst || !powered)
			rx_buf <= `ULC_BUF_RST;
		else if (rx_done)
			rx_buf <= rx_word;
	end

	// ------------------------------------------------------------
	// error flags: hardware set wins over a zero write
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst || !rx_run) begin
			par_err <= 1'b0;
			frm_err <= 1'b0;
		end else begin
			par_err <= set_pe || (par_err
				&& !(wr_stat && !reg_wdata[1]));
			frm_err <= set_fe || (frm_err
				&& !(wr_stat && !reg_wdata[0]));
		end
	end

endmodule

`default_nettype wire

// ---- tb/ulc_chk.sv ----
/*
 * port checker of ulc_top: register reads, idle pin, irq timing.
 * assumes a bind from the bench top file, one clock domain.
 */
`include "ulc_params.svh"
`default_nettype none

module ulc_chk #(
	parameter int OS_DIV = 16
) (
	input wire logic                   core_clk,
	input wire logic                   srst,
	input wire logic [`ULC_ADDR_W-1:0] reg_addr,
	input wire logic [7:0]             reg_wdata,
	input wire logic                   reg_wr,
	input wire logic                   reg_rd,
	input wire logic [7:0]             reg_rdata,
	input wire logic                   serial_in_pin,
	input wire logic                   serial_out_pin,
	input wire logic                   transmit_enable_irq
);
	// ------------------------------------------------------------
	// shadow copies of the two control registers
	// ------------------------------------------------------------
	logic [7:0] ctl;
	logic [7:0] opt;
	wire        at_ctl = reg_addr == `ULC_OFS_CTL;
	wire        at_opt = reg_addr == `ULC_OFS_OPT;
	wire        at_bad = reg_addr == `ULC_OFS_CTL + 28'h1;
	wire        power  = ctl[7];

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctl <= `ULC_CTL_RST;
			opt <= `ULC_OPT_RST;
		end else if (reg_wr) begin
			ctl <= at_ctl ? reg_wdata : ctl;
			opt <= at_opt ? reg_wdata : opt;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_off_settled;
		(!power && $stable(opt[1])) [*3];
	endsequence

	a_ctl_readback: assert property (reg_rd && at_ctl |=>
		reg_rdata == $past(ctl)) else $error("ctl readback wrong");
	a_opt_readback: assert property (reg_rd && at_opt |=>
		reg_rdata[4:0] == $past(opt[4:0])) else $error("opt readback wrong");
	a_trig_read_zero: assert property (reg_rd && at_opt |=>
		reg_rdata[6:5] == 2'b00) else $error("trigger bit read as one");
	a_unmapped_zero: assert property (reg_rd && at_bad |=>
		reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_off_pin_level: assert property (s_off_settled |->
		serial_out_pin == !opt[1]) else $error("unpowered pin level wrong");
	a_off_no_irq: assert property (!power [*2] |->
		!transmit_enable_irq) else $error("irq while unpowered");
	a_irq_one_cycle: assert property (transmit_enable_irq |=>
		!transmit_enable_irq) else $error("irq longer than one cycle");
	a_irq_start_bit: assert property (transmit_enable_irq |=>
		serial_out_pin == opt[1]) else $error("no start bit with irq");
endmodule

`default_nettype wire

// ---- tb/ulc_remote_node.sv ----
/*
 * remote serial node: drives the receive line, captures frames.
 * assumes tasks are entered just after a rising clock edge.
 */
`default_nettype none

module ulc_remote_node #(
	parameter int BIT_CLKS = 16
) (
	input  wire logic core_clk,
	input  wire logic line_in,
	output var logic  line_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial line_out = 1'b1;

	// n bits of vec, first bit first, then idle
	task automatic send_bits(input int n, input logic [31:0] vec,
		input logic inv);
		for (int i = 0; i < n; i++) begin
			line_out <= vec[i] ^ inv;
			repeat (BIT_CLKS) @(posedge core_clk);
		end
		line_out <= ~inv;
	endtask

	// mid-bit capture of n bits once the line leaves idle
	task automatic catch_bits(input int n, input logic idle,
		output logic [31:0] vec, output logic ok);
		ok = 1'b0;
		vec = '1;
		for (int w = 0; w < 200 && !ok; w++) begin
			@(posedge core_clk);
			ok = line_in !== idle;
		end
		repeat (BIT_CLKS / 2) @(posedge core_clk);
		for (int i = 0; i < n; i++) begin
			vec[i] = line_in ^ ~idle;
			repeat (BIT_CLKS) @(posedge core_clk);
		end
	endtask
endmodule

`default_nettype wire

// ---- tb/test_ulc_top.sv ----
/*
 * bench of ulc_top: registers, frame formats, break send and receive.
 * assumes ulc_params.svh on the include path, OS_DIV of one.
 */
`include "ulc_params.svh"
`default_nettype none

module test_ulc_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BITC = 16;
	logic        core_clk  = 1'b0;
	logic        srst      = 1'b1;
	logic [27:0] reg_addr  = '0;
	logic [7:0]  reg_wdata = '0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [7:0]  reg_rdata;
	logic        rx_line;
	logic        tx_line;
	logic        irq;
	int          failures  = 0;
	int          tests_run = 0;
	int          irqs      = 0;

	always #2 core_clk = ~core_clk;
	always @(posedge core_clk) if (irq === 1'b1) irqs++;

	ulc_top #(.OS_DIV(1)) i_ulc_top (.core_clk(core_clk), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in_pin(rx_line),
		.serial_out_pin(tx_line), .transmit_enable_irq(irq));
	ulc_remote_node #(.BIT_CLKS(BITC)) i_ulc_remote_node (
		.core_clk(core_clk), .line_in(tx_line), .line_out(rx_line));

	// ------------------------------------------------------------
	// bus and compare tasks
	// ------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wr(input logic [27:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rchk(input logic [27:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk("rdata", reg_rdata, e);
		@(posedge core_clk);
	endtask

	// expected line bits of one frame, idle fill above it
	function automatic logic [31:0] frame(input logic [7:0] c,
		input logic [7:0] d, output int n);
		logic [31:0] f;
		logic        p;
		f = '1;
		f[0] = 1'b0;
		p = 1'b0;
		n = 1;
		for (int i = 0; i < 7 + c[1]; i++) begin
			f[n] = c[4] ? d[i] : d[7 - i];
			p ^= f[n];
			n++;
		end
		if (c[3:2] != 2'b00) begin
			f[n] = c[3:2] == 2'b01 ? 1'b0 : (c[2] ? p : ~p);
			n++;
		end
		n += 1 + c[0];
		return f;
	endfunction

	initial begin
		repeat (100000) @(posedge core_clk);
		failures++;
		give_verdict();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		static logic [4:0] fmt [4] = '{5'b10010, 5'b00111, 5'b11000,
			5'b01101};
		logic [7:0]  c;
		logic [31:0] f1;
		logic [31:0] f2;
		logic [31:0] got;
		logic        ok;
		int          n1;
		int          n2;
		int          cnt;
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		rchk(`ULC_OFS_CTL, 8'h10);
		rchk(`ULC_OFS_OPT, 8'h14);
		rchk(`ULC_OFS_CTL + 28'h1, 8'h00);
		chk("idle_pin", tx_line, 1'b1);
		wr(`ULC_OFS_OPT, 8'h16);
		#1 chk("inv_pin", tx_line, 1'b0);
		@(posedge core_clk);
		wr(`ULC_OFS_OPT, 8'h74);
		rchk(`ULC_OFS_OPT, 8'h14);
		wr(`ULC_OFS_CTL, 8'h0F);
		rchk(`ULC_OFS_CTL, 8'h0F);
		wr(`ULC_OFS_CTL, 8'hC0);
		wr(`ULC_OFS_OPT, 8'h54);
		rchk(`ULC_OFS_OPT, 8'h14);
		wr(`ULC_OFS_CTL, 8'h80);
		wr(`ULC_OFS_CTL, 8'h00);
		for (int i = 0; i < 4; i++) begin
			c = {3'b000, fmt[i]};
			wr(`ULC_OFS_CTL, c);
			wr(`ULC_OFS_OPT, 8'h14 | (8'(i[0]) << 1));
			wr(`ULC_OFS_CTL, c | 8'h80);
			wr(`ULC_OFS_CTL, c | 8'hC0);
			f1 = frame(c, 8'hA5 ^ 8'(i), n1);
			f2 = frame(c, 8'h3C + 8'(i), n2);
			irqs = 0;
			fork
				i_ulc_remote_node.catch_bits(n1 + n2, ~i[0], got, ok);
				begin
					wr(`ULC_OFS_TXB, 8'hA5 ^ 8'(i));
					for (int w = 0; w < 20 && irqs == 0; w++)
						@(posedge core_clk);
					wr(`ULC_OFS_TXB, 8'h3C + 8'(i));
				end
			join
			chk("start", ok, 1'b1);
			f1 = (f1 & ((32'h1 << n1) - 1)) | (f2 << n1);
			f1 |= ~((32'h1 << (n1 + n2)) - 1);
			chk("frames", got, f1);
			chk("irqs", irqs, 2);
			wr(`ULC_OFS_CTL, c | 8'h80);
			wr(`ULC_OFS_CTL, c);
		end
		wr(`ULC_OFS_OPT, 8'h14);
		for (int k = 0; k < 8; k++) begin
			wr(`ULC_OFS_CTL, 8'h90);
			wr(`ULC_OFS_OPT, 8'(k) << 2);
			wr(`ULC_OFS_CTL, 8'hD0);
			wr(`ULC_OFS_OPT, 8'h20 | (8'(k) << 2));
			for (int w = 0; w < 50 && tx_line; w++) @(posedge core_clk);
			for (cnt = 0; cnt < 400 && !tx_line; cnt++) @(posedge core_clk);
			n1 = k >= 5 ? k + 8 : k + 16;
			chk("brk_bits", (cnt + BITC / 2) / BITC, n1);
			repeat (2 * BITC) @(posedge core_clk);
			rchk(`ULC_OFS_OPT, 8'(k) << 2);
		end
		wr(`ULC_OFS_CTL, 8'h90);
		wr(`ULC_OFS_CTL, 8'h00);
		wr(`ULC_OFS_OPT, 8'h14);
		wr(`ULC_OFS_CTL, 8'h80);
		wr(`ULC_OFS_CTL, 8'hA0);
		wr(`ULC_OFS_OPT, 8'h54);
		rchk(`ULC_OFS_OPT, 8'h94);
		i_ulc_remote_node.send_bits(5, '0, 1'b0);
		repeat (BITC) @(posedge core_clk);
		rchk(`ULC_OFS_OPT, 8'h94);
		i_ulc_remote_node.send_bits(12, '0, 1'b0);
		repeat (BITC) @(posedge core_clk);
		rchk(`ULC_OFS_OPT, 8'h14);
		wr(`ULC_OFS_OPT, 8'h54);
		wr(`ULC_OFS_CTL, 8'h80);
		wr(`ULC_OFS_CTL, 8'h00);
		rchk(`ULC_OFS_OPT, 8'h14);
		wr(`ULC_OFS_OPT, 8'h15);
		i_ulc_remote_node.send_bits(0, '0, 1'b1);
		wr(`ULC_OFS_CTL, 8'h1A);
		wr(`ULC_OFS_CTL, 8'h9A);
		wr(`ULC_OFS_CTL, 8'hBA);
		f1 = frame(8'h1A, 8'h5B, n1);
		i_ulc_remote_node.send_bits(n1, f1, 1'b1);
		rchk(`ULC_OFS_RXB, 8'h5B);
		rchk(`ULC_OFS_STAT, 8'h00);
		i_ulc_remote_node.send_bits(n1, f1 ^ 32'h200, 1'b1);
		rchk(`ULC_OFS_STAT, 8'h02);
		wr(`ULC_OFS_CTL, 8'h9A);
		wr(`ULC_OFS_CTL, 8'h16);
		wr(`ULC_OFS_CTL, 8'h96);
		wr(`ULC_OFS_CTL, 8'hB6);
		f1 = frame(8'h16, 8'h5B, n1);
		i_ulc_remote_node.send_bits(n1, f1 | 32'h200, 1'b1);
		rchk(`ULC_OFS_STAT, 8'h00);
		rchk(`ULC_OFS_RXB, 8'h5B);
		give_verdict();
	end
endmodule

bind ulc_top ulc_chk #(.OS_DIV(OS_DIV)) i_ulc_chk (.core_clk(core_clk),
	.srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
	.transmit_enable_irq(transmit_enable_irq));

`default_nettype wire
